// ---- core/dsc_dev.sv ----
// Decided for this implementation: the register addresses and the APB slave port.
`timescale 1ns/1ps
module dsc_dev
    import dsc_pkg::*;
#(
    parameter int DATA_W = 16
) (
    input  wire logic              clk_sys,
    input  wire logic              rst_b,
    dsc_link_if.dev                link,
    input  wire logic              short_circuit,
    input  wire logic              brownout,
    input  wire logic              overtemp,
    output logic      [DATA_W-1:0] dac_code,
    output logic                   output_clamped,
    output logic                   thermal_supply_cutoff
);
    import dsc_pkg::*;

    // Pin order: sclk, sync, data in, load, clear, reset, short, brownout, overtemp.
    logic [8:0] pin_q, pin_rise, pin_fall;

    dsc_sync #(.W(9), .INIT(9'h1b8)) u_sync (
        .clk_sys (clk_sys),
        .rst_b   (rst_b),
        .d       ({link.sclk, link.sync_n, link.serial_data_in, link.load_output_n, link.clear_n,
                   link.reset_n, short_circuit, brownout, overtemp}),
        .q       (pin_q),
        .rise    (pin_rise),
        .fall    (pin_fall)
    );

    logic sclk_rise, sclk_fall, sync_q, sync_rise, sync_fall, sdi_q;
    logic load_q, load_fall, clear_fall, reset_q, short_q, brown_q, ot_q;
    assign sclk_rise  = pin_rise[8];
    assign sclk_fall  = pin_fall[8];
    assign sync_q     = pin_q[7];
    assign sync_rise  = pin_rise[7];
    assign sync_fall  = pin_fall[7];
    assign sdi_q      = pin_q[6];
    assign load_q     = pin_q[5];
    assign load_fall  = pin_fall[5];
    assign clear_fall = pin_fall[4];
    assign reset_q    = pin_q[3];
    assign short_q    = pin_q[2];
    assign brown_q    = pin_q[1];
    assign ot_q       = pin_q[0];

    logic [FRAME_BITS-1:0] sr_r, sr_nxt;
    logic [CNT_W-1:0]      cnt_r, cnt_nxt;
    logic                  load_hi_r, load_hi_nxt;
    logic                  sdo_r, sdo_nxt, sdo_oe_r, sdo_oe_nxt;
    logic                  rb_pend_r, rb_pend_nxt;
    logic [3:0]            rb_cmd_r, rb_cmd_nxt;
    logic [DATA_W-1:0]     in_r, in_nxt, dac_r, dac_nxt;
    logic [CTRL_W-1:0]     ctrl_r, ctrl_nxt;
    logic                  short_r, short_nxt, brown_r, brown_nxt;
    logic                  cfg_r, cfg_nxt, chain_r, chain_nxt;
    logic                  off_r, off_nxt, alert_n_r, alert_n_nxt;

    // Scale code for a two-bit zero/mid/full selector.
    function automatic logic [DATA_W-1:0] scale_val(input logic [1:0] sel);
        logic [DATA_W-1:0] v;
        v = '0;
        if (sel == 2'h1) begin
            v[DATA_W-1] = 1'b1;
        end else if (sel[1]) begin
            v = '1;
        end
        return v;
    endfunction

    logic [DATA_W-1:0] frame_val;
    logic [3:0]        frame_cmd;
    logic              frame_ok;
    logic [15:0]       rb_val;
    logic [FRAME_BITS-1:0] rb_word;

    assign frame_val = sr_r[VALUE_MSB -: DATA_W];
    assign frame_cmd = sr_r[CMD_MSB:CMD_LSB];
    // A chained frame is accepted once at least one full word went past.
    assign frame_ok  = (cnt_r == CNT_W'(FRAME_BITS)) || (chain_r && cnt_r > CNT_W'(FRAME_BITS));

    // Readback word, value left aligned so the short variant reads like the long one.
    always_comb begin
        unique case (rb_cmd_r)
            CMD_RB_IN:  rb_val = 16'(in_r) << (16 - DATA_W);
            CMD_RB_DAC: rb_val = 16'(dac_r) << (16 - DATA_W);
            default:    rb_val = {3'h0, short_r, brown_r, ctrl_r};
        endcase
        rb_word = {4'h0, rb_cmd_r, rb_val};
    end

    // Whole device state: frame engine, command decode, pins and faults.
    always_comb begin
        sr_nxt      = sr_r;
        cnt_nxt     = cnt_r;
        load_hi_nxt = load_hi_r;
        sdo_nxt     = sdo_r;
        sdo_oe_nxt  = sdo_oe_r;
        rb_pend_nxt = rb_pend_r;
        rb_cmd_nxt  = rb_cmd_r;
        in_nxt      = in_r;
        dac_nxt     = dac_r;
        ctrl_nxt    = ctrl_r;
        short_nxt   = short_r;
        brown_nxt   = brown_r;
        cfg_nxt     = cfg_r;
        chain_nxt   = chain_r;
        off_nxt     = off_r;
        alert_n_nxt = cfg_r && !(short_r || brown_r || ot_q);

        if (sync_fall) begin
            cnt_nxt     = '0;
            load_hi_nxt = load_q;
            sdo_oe_nxt  = chain_r || rb_pend_r;
            if (rb_pend_r) begin
                sr_nxt      = rb_word;
                sdo_nxt     = rb_word[FRAME_BITS-1];
                rb_pend_nxt = 1'b0;
                if (rb_cmd_r == CMD_RB_CTRL) begin
                    short_nxt = 1'b0;
                    brown_nxt = 1'b0;
                end
            end else begin
                sdo_nxt = sr_r[FRAME_BITS-1];
            end
        end else if (!sync_q) begin
            if (load_q) begin
                load_hi_nxt = 1'b1;
            end
            if (sclk_fall) begin
                sr_nxt = {sr_r[FRAME_BITS-2:0], sdi_q};
                if (cnt_r != CNT_MAX) begin
                    cnt_nxt = cnt_r + CNT_W'(1);
                end
            end
            // The bit that falls off the top leads the falling edge by half a clock.
            if (sclk_rise && cnt_r != '0) begin
                sdo_nxt = sr_r[FRAME_BITS-1];
            end
        end

        if (sync_rise) begin
            sdo_oe_nxt = 1'b0;
            if (frame_ok) begin
                unique case (frame_cmd)
                    CMD_WR_IN: begin
                        in_nxt = frame_val;
                        if (!load_hi_r) begin
                            dac_nxt = frame_val;
                        end
                    end
                    CMD_UPD:    dac_nxt = in_r;
                    CMD_WR_UPD: begin
                        in_nxt  = frame_val;
                        dac_nxt = frame_val;
                    end
                    CMD_WR_CTRL: begin
                        ctrl_nxt = sr_r[CTRL_W-1:0];
                        cfg_nxt  = 1'b1;
                    end
                    CMD_DATA_RST: begin
                        in_nxt  = scale_val(ctrl_r[CTRL_PV_MSB:CTRL_PV_LSB]);
                        dac_nxt = scale_val(ctrl_r[CTRL_PV_MSB:CTRL_PV_LSB]);
                    end
                    CMD_CHAIN_OFF: chain_nxt = 1'b0;
                    CMD_RB_IN, CMD_RB_DAC, CMD_RB_CTRL: begin
                        rb_pend_nxt = 1'b1;
                        rb_cmd_nxt  = frame_cmd;
                    end
                    default: ;
                endcase
            end
        end

        // Asynchronous update acts only while the frame is closed; a load fall inside a frame is dropped.
        if (load_fall && sync_q) begin
            dac_nxt = in_r;
        end

        // Clear acts after the updates so it wins against a same-cycle update.
        if (clear_fall) begin
            dac_nxt = scale_val(ctrl_r[CTRL_CV_MSB:CTRL_CV_LSB]);
        end

        // Fault flags set after the readback clear above, so a new event is kept.
        if (short_q) begin
            short_nxt = 1'b1;
        end
        if (brown_q) begin
            brown_nxt = 1'b1;
        end
        if (ot_q && ctrl_r[CTRL_CUTOFF]) begin
            off_nxt = 1'b1;
        end

        // A dead supply ignores the link except that a control write still sets cfg_r; only a pin reset brings it back.
        if (off_r) begin
            sr_nxt      = sr_r;
            cnt_nxt     = cnt_r;
            sdo_oe_nxt  = 1'b0;
            rb_pend_nxt = rb_pend_r;
            in_nxt      = in_r;
            dac_nxt     = dac_r;
            ctrl_nxt    = ctrl_r;
            chain_nxt   = chain_r;
            alert_n_nxt = 1'b0;
        end

        if (!reset_q || (sync_rise && frame_ok && frame_cmd == CMD_FULL_RST && !off_r)) begin
            in_nxt      = '0;
            dac_nxt     = '0;
            ctrl_nxt    = CTRL_RST;
            short_nxt   = 1'b0;
            brown_nxt   = 1'b0;
            cfg_nxt     = 1'b0;
            chain_nxt   = 1'b1;
            rb_pend_nxt = 1'b0;
            alert_n_nxt = 1'b0;
            off_nxt     = !reset_q ? 1'b0 : off_r;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            sr_r      <= '0;
            cnt_r     <= '0;
            load_hi_r <= 1'b0;
            sdo_r     <= 1'b0;
            sdo_oe_r  <= 1'b0;
            rb_pend_r <= 1'b0;
            rb_cmd_r  <= 4'h0;
            in_r      <= '0;
            dac_r     <= '0;
            ctrl_r    <= CTRL_RST;
            short_r   <= 1'b0;
            brown_r   <= 1'b0;
            cfg_r     <= 1'b0;
            chain_r   <= 1'b1;
            off_r     <= 1'b0;
            alert_n_r <= 1'b0;
        end else begin
            sr_r      <= sr_nxt;
            cnt_r     <= cnt_nxt;
            load_hi_r <= load_hi_nxt;
            sdo_r     <= sdo_nxt;
            sdo_oe_r  <= sdo_oe_nxt;
            rb_pend_r <= rb_pend_nxt;
            rb_cmd_r  <= rb_cmd_nxt;
            in_r      <= in_nxt;
            dac_r     <= dac_nxt;
            ctrl_r    <= ctrl_nxt;
            short_r   <= short_nxt;
            brown_r   <= brown_nxt;
            cfg_r     <= cfg_nxt;
            chain_r   <= chain_nxt;
            off_r     <= off_nxt;
            alert_n_r <= alert_n_nxt;
        end
    end

    assign link.serial_data_out_o  = sdo_r;
    assign link.serial_data_out_oe = sdo_oe_r;
    assign link.alert_n            = alert_n_r;
    assign dac_code                = dac_r;
    assign output_clamped          = !cfg_r;
    assign thermal_supply_cutoff   = off_r;
endmodule // dsc_dev

// ---- core/dsc_pkg.sv ----
package dsc_pkg;
    // Serial frame shape.
    localparam int FRAME_BITS = 24;
    localparam int CMD_MSB    = 19;
    localparam int CMD_LSB    = 16;
    localparam int FIXED_BIT  = 20;
    localparam int VALUE_MSB  = 15;
    localparam int CNT_W      = 7;
    localparam logic [CNT_W-1:0] CNT_MAX = 7'h7f;

    // Command codes carried in the frame.
    localparam logic [3:0] CMD_WR_IN    = 4'h1;
    localparam logic [3:0] CMD_UPD      = 4'h2;
    localparam logic [3:0] CMD_WR_UPD   = 4'h3;
    localparam logic [3:0] CMD_WR_CTRL  = 4'h4;
    localparam logic [3:0] CMD_DATA_RST = 4'h7;
    localparam logic [3:0] CMD_CHAIN_OFF = 4'h9;
    localparam logic [3:0] CMD_RB_IN    = 4'ha;
    localparam logic [3:0] CMD_RB_DAC   = 4'hb;
    localparam logic [3:0] CMD_RB_CTRL  = 4'hc;
    localparam logic [3:0] CMD_FULL_RST = 4'hf;

    // Device control register layout.
    localparam int CTRL_W      = 11;
    localparam int CTRL_SHORT  = 12;
    localparam int CTRL_BROWN  = 11;
    localparam int CTRL_CV_MSB = 10;
    localparam int CTRL_CV_LSB = 9;
    localparam int CTRL_CUTOFF = 6;
    localparam int CTRL_PV_MSB = 4;
    localparam int CTRL_PV_LSB = 3;
    localparam logic [CTRL_W-1:0] CTRL_RST = 11'h000;

    // Controller register map, byte addresses.
    localparam logic [7:0] OFS_CTRL   = 8'h00;
    localparam logic [7:0] OFS_TX     = 8'h04;
    localparam logic [7:0] OFS_RX     = 8'h08;
    localparam logic [7:0] OFS_STATUS = 8'h0c;
    localparam logic [7:0] OFS_IRQ_ST = 8'h10;
    localparam logic [7:0] OFS_IRQ_MK = 8'h14;
    localparam int HC_START = 0;
    localparam int HC_LOAD  = 1;
    localparam int HC_CLEAR = 2;
    localparam int HC_RESET = 3;
    localparam int IRQ_DONE  = 0;
    localparam int IRQ_ALERT = 1;

    // Timing.
    localparam int CLK_NS       = 10;
    localparam int CLEAR_LOW_NS = 20;
    localparam int CLEAR_LOW_CYC = (CLEAR_LOW_NS + CLK_NS - 1) / CLK_NS;
    localparam int SCLK_HALF_CYC = 8;
endpackage

// ---- core/dsc_link_if.sv ----
`timescale 1ns/1ps
interface dsc_link_if;
    logic sclk;
    logic sync_n;
    logic serial_data_in;
    logic serial_data_out_o;
    logic serial_data_out_oe;
    logic serial_data_out;
    logic load_output_n;
    logic clear_n;
    logic reset_n;
    logic alert_n;

    // Undriven output reads low, as through a weak pull-down.
    assign serial_data_out = serial_data_out_oe & serial_data_out_o;

    modport host (output sclk, output sync_n, output serial_data_in, input serial_data_out,
                  output load_output_n, output clear_n, output reset_n, input alert_n);
    modport dev  (input sclk, input sync_n, input serial_data_in, output serial_data_out_o,
                  output serial_data_out_oe, input load_output_n, input clear_n, input reset_n,
                  output alert_n);
endinterface

// ---- core/dsc_sync.sv ----
`timescale 1ns/1ps
module dsc_sync #(
    parameter int           W    = 1,
    parameter logic [W-1:0] INIT = '0
) (
    input  wire logic         clk_sys,
    input  wire logic         rst_b,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q,
    output logic      [W-1:0] rise,
    output logic      [W-1:0] fall
);
    logic [W-1:0] meta_r, meta_nxt, q_r, q_nxt, prev_r, prev_nxt;

    // Only the second stage and its delayed copy feed the edge detectors.
    always_comb begin
        meta_nxt = d;
        q_nxt    = meta_r;
        prev_nxt = q_r;
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            meta_r <= INIT;
            q_r    <= INIT;
            prev_r <= INIT;
        end else begin
            meta_r <= meta_nxt;
            q_r    <= q_nxt;
            prev_r <= prev_nxt;
        end
    end

    assign q    = q_r;
    assign rise = q_r & ~prev_r;
    assign fall = ~q_r & prev_r;
endmodule // dsc_sync

// ---- core/dsc_host.sv ----
`timescale 1ns/1ps
module dsc_host
    import dsc_pkg::*;
#(
    parameter int SCLK_HALF = SCLK_HALF_CYC
) (
    input  wire logic        clk_sys,
    input  wire logic        rst_b,
    dsc_link_if.host         link,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             irq
);
    import dsc_pkg::*;

    typedef enum logic {HS_IDLE, HS_RUN} dsc_hstate_e;

    logic [1:0] in_q;
    logic [1:0] in_fall;

    dsc_sync #(.W(2), .INIT(2'h0)) u_sync (
        .clk_sys (clk_sys),
        .rst_b   (rst_b),
        .d       ({link.serial_data_out, link.alert_n}),
        .q       (in_q),
        .rise    (),
        .fall    (in_fall)
    );

    dsc_hstate_e           st_r, st_nxt;
    logic [FRAME_BITS-1:0] tx_r, tx_nxt, rx_r, rx_nxt;
    logic [7:0]            div_r, div_nxt;
    logic [4:0]            bit_r, bit_nxt;
    logic                  sclk_r, sclk_nxt, sync_n_r, sync_n_nxt, sdi_r, sdi_nxt;
    logic                  load_r, load_nxt, rst_pin_r, rst_pin_nxt;
    logic [1:0]            clr_r, clr_nxt;
    logic [1:0]            ist_r, ist_nxt, imask_r, imask_nxt;
    logic [31:0]           prdata_r, prdata_nxt;

    logic acc, wr, rd, mapped;
    assign acc    = psel && penable;
    assign wr     = acc && pwrite;
    assign rd     = acc && !pwrite;
    assign mapped = paddr inside {OFS_CTRL, OFS_TX, OFS_RX, OFS_STATUS, OFS_IRQ_ST, OFS_IRQ_MK};

    // Register file, sclk divider and frame sequencer.
    always_comb begin
        st_nxt      = st_r;
        tx_nxt      = tx_r;
        rx_nxt      = rx_r;
        div_nxt     = div_r;
        bit_nxt     = bit_r;
        sclk_nxt    = sclk_r;
        sync_n_nxt  = sync_n_r;
        sdi_nxt     = sdi_r;
        load_nxt    = load_r;
        rst_pin_nxt = rst_pin_r;
        clr_nxt     = (clr_r != 2'h0) ? clr_r - 2'h1 : 2'h0;
        ist_nxt     = ist_r;
        imask_nxt   = imask_r;
        prdata_nxt  = prdata_r;

        // Read data is fetched in the setup cycle so the access cycle can answer at once.
        if (psel && !penable && !pwrite) begin
            unique case (paddr)
                OFS_CTRL:   prdata_nxt = {28'h0, rst_pin_r, 1'b0, load_r, 1'b0};
                OFS_TX:     prdata_nxt = {8'h0, tx_r};
                OFS_RX:     prdata_nxt = {8'h0, rx_r};
                OFS_STATUS: prdata_nxt = {30'h0, in_q[0], st_r == HS_RUN};
                OFS_IRQ_ST: prdata_nxt = {30'h0, ist_r};
                OFS_IRQ_MK: prdata_nxt = {30'h0, imask_r};
                default:    prdata_nxt = 32'h0;
            endcase
        end
        if (rd && paddr == OFS_IRQ_ST) begin
            ist_nxt = 2'h0;
        end
        if (wr) begin
            unique case (paddr)
                OFS_CTRL: begin
                    load_nxt    = pwdata[HC_LOAD];
                    rst_pin_nxt = pwdata[HC_RESET];
                    if (pwdata[HC_CLEAR]) begin
                        clr_nxt = 2'(CLEAR_LOW_CYC);
                    end
                end
                OFS_TX: begin
                    tx_nxt = pwdata[FRAME_BITS-1:0];
                    tx_nxt[FIXED_BIT] = 1'b0;
                end
                OFS_IRQ_MK: imask_nxt = pwdata[1:0];
                default: ;
            endcase
        end

        unique case (st_r)
            HS_IDLE: begin
                if (wr && paddr == OFS_CTRL && pwdata[HC_START]) begin
                    st_nxt     = HS_RUN;
                    sync_n_nxt = 1'b0;
                    sdi_nxt    = tx_r[FRAME_BITS-1];
                    div_nxt    = 8'h0;
                    bit_nxt    = 5'h0;
                end
            end
            HS_RUN: begin
                if (div_r == 8'(SCLK_HALF - 1)) begin
                    div_nxt  = 8'h0;
                    sclk_nxt = !sclk_r;
                    if (sclk_r) begin
                        rx_nxt = {rx_r[FRAME_BITS-2:0], in_q[1]};
                    end else if (bit_r == 5'(FRAME_BITS - 1)) begin
                        st_nxt     = HS_IDLE;
                        sync_n_nxt = 1'b1;
                        ist_nxt[IRQ_DONE] = 1'b1;
                    end else begin
                        bit_nxt = bit_r + 5'h1;
                        sdi_nxt = tx_r[5'(FRAME_BITS - 2) - bit_r];
                    end
                end else begin
                    div_nxt = div_r + 8'h1;
                end
            end
        endcase

        // Alert drop is latched after the read clear so it is never lost.
        if (in_fall[0]) begin
            ist_nxt[IRQ_ALERT] = 1'b1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            st_r      <= HS_IDLE;
            tx_r      <= '0;
            rx_r      <= '0;
            div_r     <= 8'h0;
            bit_r     <= 5'h0;
            sclk_r    <= 1'b1;
            sync_n_r  <= 1'b1;
            sdi_r     <= 1'b0;
            load_r    <= 1'b1;
            rst_pin_r <= 1'b0;
            clr_r     <= 2'h0;
            ist_r     <= 2'h0;
            imask_r   <= 2'h0;
            prdata_r  <= 32'h0;
        end else begin
            st_r      <= st_nxt;
            tx_r      <= tx_nxt;
            rx_r      <= rx_nxt;
            div_r     <= div_nxt;
            bit_r     <= bit_nxt;
            sclk_r    <= sclk_nxt;
            sync_n_r  <= sync_n_nxt;
            sdi_r     <= sdi_nxt;
            load_r    <= load_nxt;
            rst_pin_r <= rst_pin_nxt;
            clr_r     <= clr_nxt;
            ist_r     <= ist_nxt;
            imask_r   <= imask_nxt;
            prdata_r  <= prdata_nxt;
        end
    end

    assign link.sclk           = sclk_r;
    assign link.sync_n         = sync_n_r;
    assign link.serial_data_in = sdi_r;
    assign link.load_output_n  = load_r;
    assign link.clear_n        = (clr_r == 2'h0);
    assign link.reset_n        = !rst_pin_r;
    assign prdata              = prdata_r;
    assign pready              = 1'b1;
    assign pslverr             = acc && !mapped;
    assign irq                 = |(ist_r & imask_r);
endmodule // dsc_host

// ---- verif/dsc_monitor.sv ----
`timescale 1ns/1ps
// Watches the link between host and device; all signals are plain copies.
module dsc_monitor (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic sclk,
    input wire logic sync_n,
    input wire logic serial_data_in,
    input wire logic serial_data_out_o,
    input wire logic serial_data_out_oe,
    input wire logic clear_n,
    input wire logic reset_n,
    input wire logic alert_n
);
    logic [4:0] fall_r;
    logic [4:0] fall_nxt;
    logic       sclk_r;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    // Falling link-clock edges inside the current frame; cleared while idle.
    always_comb begin
        fall_nxt = sync_n ? 5'h00 : fall_r + {4'h0, sclk_r & ~sclk};
    end
    always_ff @(posedge clk_sys) begin
        sclk_r <= rst_b ? sclk : 1'b1;
        fall_r <= rst_b ? fall_nxt : 5'h00;
    end
    a_frame_falls: assert property ($rose(sync_n) |-> fall_r == 5'h18)
        else $error("frame without exactly 24 falling edges");
    a_sdi_at_fall: assert property (!sync_n && sclk_r && !sclk |-> $stable(serial_data_in))
        else $error("data moved at a sampling edge");
    a_sclk_idle: assert property (sync_n && $past(sync_n) |-> sclk)
        else $error("link clock not idle high");
    a_sdo_released: assert property (sync_n[*6] |-> !serial_data_out_oe)
        else $error("serial out driven while idle");
    a_sdo_steady: assert property (!sync_n && sclk_r && !sclk |-> $stable(serial_data_out_o)[*3])
        else $error("serial out moved near a falling edge");
    a_clear_pulse: assert property ($fell(clear_n) |=> !clear_n ##1 clear_n)
        else $error("clear pulse not two cycles");
    a_alert_reset: assert property (!reset_n[*6] |-> !alert_n)
        else $error("alert high during reset");
    a_alert_hold: assert property ($rose(reset_n) |-> !alert_n[*8])
        else $error("alert rose without configuration");
    // Main scenarios reached.
    cover property ($rose(serial_data_out_oe));
    cover property ($fell(clear_n));
    cover property ($rose(alert_n));
endmodule // dsc_monitor

// ---- verif/dac_serial_command_update_ctrl_tb_top.sv ----
`timescale 1ns/1ps
module dac_serial_command_update_ctrl_tb_top;
    import dsc_pkg::*;
    logic        clk_sys = 1'b0;
    logic        rst_b = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic [31:0] rd;
    logic        pready, pslverr, irq, err, cutoff, clamped;
    logic        short_in = 1'b0;
    logic        brown_in = 1'b0;
    logic        ot = 1'b0;
    logic        ld = 1'b1;
    logic [15:0] dac;
    int          bad_count = 0;
    int          cmp_count = 0;
    // Free-running system clock.
    always #5 clk_sys = ~clk_sys;
    dsc_link_if dsc_link_if_i ();
    dsc_host dsc_host_i (.clk_sys(clk_sys), .rst_b(rst_b), .link(dsc_link_if_i.host), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .irq(irq));
    dsc_dev dsc_dev_i (.clk_sys(clk_sys), .rst_b(rst_b), .link(dsc_link_if_i.dev), .short_circuit(short_in),
        .brownout(brown_in), .overtemp(ot), .dac_code(dac), .output_clamped(clamped),
        .thermal_supply_cutoff(cutoff));
    dsc_monitor dsc_monitor_i (.clk_sys(clk_sys), .rst_b(rst_b), .sclk(dsc_link_if_i.sclk),
        .sync_n(dsc_link_if_i.sync_n), .serial_data_in(dsc_link_if_i.serial_data_in),
        .serial_data_out_o(dsc_link_if_i.serial_data_out_o), .clear_n(dsc_link_if_i.clear_n),
        .serial_data_out_oe(dsc_link_if_i.serial_data_out_oe), .reset_n(dsc_link_if_i.reset_n),
        .alert_n(dsc_link_if_i.alert_n));
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask
    // One APB transfer; an idle cycle follows so psel is never assigned twice in a step.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        @(posedge clk_sys);
        while (pready !== 1'b1) begin
            @(posedge clk_sys);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys);
    endtask
    task automatic rdchk(input string n, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(n, e, rd & m);
    endtask
    task automatic ctl(input logic [3:0] v);
        apb(1'b1, OFS_CTRL, {28'h0, v[3:2], ld, v[0]});
    endtask
    // Sends one frame and waits until the host is idle and the device has acted.
    task automatic frame(input logic [23:0] f);
        apb(1'b1, OFS_TX, {8'h00, f});
        ctl(4'h1);
        rd = 32'h1;
        while (rd[0] !== 1'b0) begin
            apb(1'b0, OFS_STATUS, 32'h0);
        end
        repeat (8) @(posedge clk_sys);
    endtask
    task automatic final_report;
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // Cuts a hang short well beyond the expected run length.
    initial begin
        repeat (60000) @(posedge clk_sys);
        bad_count++;
        final_report();
    end
    initial begin
        repeat (3) @(posedge clk_sys);
        rst_b <= 1'b1;
        @(posedge clk_sys);
        rdchk("alert", OFS_STATUS, 32'h2, 32'h0);
        chk("clamped", 32'h1, {31'h0, clamped});
        rdchk("unmapped", 8'h20, 32'hffffffff, 32'h0);
        chk("slverr", 32'h1, {31'h0, err});
        frame(24'h040200);
        rdchk("alert", OFS_STATUS, 32'h2, 32'h2);
        chk("clamped", 32'h0, {31'h0, clamped});
        frame(24'h011234);
        chk("dac", 32'h0, {16'h0, dac});
        ld = 1'b0;
        ctl(4'h0);
        repeat (8) @(posedge clk_sys);
        chk("dac", 32'h1234, {16'h0, dac});
        frame(24'h015678);
        chk("dac", 32'h5678, {16'h0, dac});
        ld = 1'b1;
        ctl(4'h0);
        frame(24'he3abcd);
        chk("dac", 32'habcd, {16'h0, dac});
        frame(24'h011111);
        chk("dac", 32'habcd, {16'h0, dac});
        frame(24'h020000);
        chk("dac", 32'h1111, {16'h0, dac});
        frame(24'h0a0000);
        frame(24'h000000);
        rdchk("readback", OFS_RX, 32'hffffff, 32'h0a1111);
        ctl(4'h4);
        repeat (8) @(posedge clk_sys);
        chk("clear", 32'h8000, {16'h0, dac});
        frame(24'h011234);
        chk("clear hold", 32'h8000, {16'h0, dac});
        frame(24'h020000);
        chk("dac", 32'h1234, {16'h0, dac});
        apb(1'b1, OFS_IRQ_MK, 32'h0);
        chk("irq off", 32'h0, {31'h0, irq});
        apb(1'b1, OFS_IRQ_MK, 32'h3);
        chk("irq mask", 32'h1, {31'h0, irq});
        rdchk("irq stat", OFS_IRQ_ST, 32'h1, 32'h1);
        chk("irq", 32'h0, {31'h0, irq});
        short_in <= 1'b1;
        repeat (10) @(posedge clk_sys);
        short_in <= 1'b0;
        rdchk("alert", OFS_STATUS, 32'h2, 32'h0);
        frame(24'h0c0000);
        frame(24'h000000);
        rdchk("ctrl rb", OFS_RX, 32'hffffff, 32'h0c1200);
        brown_in <= 1'b1;
        repeat (10) @(posedge clk_sys);
        brown_in <= 1'b0;
        frame(24'h0c0000);
        frame(24'h000000);
        rdchk("ctrl rb", OFS_RX, 32'hffffff, 32'h0c0a00);
        ot <= 1'b1;
        repeat (10) @(posedge clk_sys);
        rdchk("alert", OFS_STATUS, 32'h2, 32'h0);
        chk("cutoff", 32'h0, {31'h0, cutoff});
        ot <= 1'b0;
        frame(24'h040240);
        ot <= 1'b1;
        repeat (10) @(posedge clk_sys);
        ot <= 1'b0;
        chk("cutoff", 32'h1, {31'h0, cutoff});
        ctl(4'h8);
        repeat (10) @(posedge clk_sys);
        ctl(4'h0);
        chk("cutoff", 32'h0, {31'h0, cutoff});
        rdchk("alert", OFS_STATUS, 32'h2, 32'h0);
        chk("clamped", 32'h1, {31'h0, clamped});
        frame(24'h040200);
        frame(24'h03abcd);
        frame(24'h0f0000);
        chk("dac", 32'h0, {16'h0, dac});
        rdchk("alert", OFS_STATUS, 32'h2, 32'h0);
        frame(24'h040200);
        frame(24'h03abcd);
        frame(24'h070000);
        chk("dac", 32'h0, {16'h0, dac});
        rdchk("alert", OFS_STATUS, 32'h2, 32'h2);
        final_report();
    end
endmodule // dac_serial_command_update_ctrl_tb_top
